// ### core/ptm_pkg.sv
/*
 ptm_pkg: register offsets, field positions, codes and reset values of the periodic timer unit.
 assumes: a 32-bit apb slave with byte-wide registers in the low lanes, one aligned word each.
*/
package ptm_pkg;
   localparam int PTM_ADDR_W = 8;
   localparam int PTM_DATA_W = 32;

   // byte addresses
   localparam logic [7:0] PTM_OFS_CTRL = 8'h00;
   localparam logic [7:0] PTM_OFS_RUN = 8'h04;
   localparam logic [7:0] PTM_OFS_CNT_LO = 8'h08;
   localparam logic [7:0] PTM_OFS_CNT_HI = 8'h0C;
   localparam logic [7:0] PTM_OFS_DUTY_LO = 8'h10;
   localparam logic [7:0] PTM_OFS_DUTY_HI = 8'h14;
   localparam logic [7:0] PTM_OFS_PER_LO = 8'h18;
   localparam logic [7:0] PTM_OFS_PER_HI = 8'h1C;
   localparam logic [7:0] PTM_OFS_FLAG = 8'h20;

   // timer_control_one fields
   localparam int PTM_MODE_HI = 7;
   localparam int PTM_MODE_LO = 6;
   localparam int PTM_IO_HI = 5;
   localparam int PTM_IO_LO = 4;
   localparam int PTM_OC_BIT = 3;
   localparam int PTM_POL_BIT = 2;
   localparam int PTM_CCLR_BIT = 0;

   // run register fields
   localparam int PTM_RUN_BIT = 0;
   localparam int PTM_DIV_LO = 1;
   localparam int PTM_DIV_HI = 3;

   // flag register fields
   localparam int PTM_FLAG_A_BIT = 0;
   localparam int PTM_FLAG_P_BIT = 1;

   // mode_select_bits codes
   localparam logic [1:0] PTM_MODE_CMP = 2'h0;
   localparam logic [1:0] PTM_MODE_CAP = 2'h1;
   localparam logic [1:0] PTM_MODE_PWM = 2'h2;
   localparam logic [1:0] PTM_MODE_TMR = 2'h3;

   // pin_action_bits codes, compare-match mode
   localparam logic [1:0] PTM_IO_NONE = 2'h0;
   localparam logic [1:0] PTM_IO_LOW = 2'h1;
   localparam logic [1:0] PTM_IO_HIGH = 2'h2;
   localparam logic [1:0] PTM_IO_TOGGLE = 2'h3;

   // pin_action_bits codes, pwm mode
   localparam logic [1:0] PTM_PWM_INACT = 2'h0;
   localparam logic [1:0] PTM_PWM_ACT = 2'h1;
   localparam logic [1:0] PTM_PWM_WAVE = 2'h2;
   localparam logic [1:0] PTM_PWM_PULSE = 2'h3;

   // counter widths and masks
   localparam int PTM_WIDE_W = 16;
   localparam int PTM_NARROW_W = 10;
   localparam logic [15:0] PTM_MAX_WIDE = 16'hFFFF;
   localparam logic [15:0] PTM_MAX_NARROW = 16'h03FF;

   // reset values and the divider unit constant
   localparam logic [7:0] PTM_BYTE_RST = 8'h00;
   localparam logic [15:0] PTM_WORD_RST = 16'h0000;
   localparam logic [7:0] PTM_DIV_ONE = 8'h01;
endpackage : ptm_pkg

// ### core/ptm_timer.sv
/*
 ptm_timer: periodic timer unit with one up-counter, duty and period comparators, compare-match,
 timer/counter, pwm and single-pulse modes, and an apb register slave.
 assumes: one clock, asynchronous active-high reset, an apb master that keeps the protocol.
*/
// The register offsets and the APB slave port were left to the implementer.
// Function
// - count readable as read-only low/high bytes
// - narrow unit high bytes read upper zero
// - duty compare value read/write, two bytes
// - period compare value read/write, two bytes
// - mode bits pick compare, pwm, timer
// - clear source low: clear on period match
// - clear source high: clear on duty match in compare and timer modes
// - zero duty: overflow at max, no flag
// - compare mode pin acts on duty match
// - run rise loads initial pin level
// - timer mode counts like compare, no pin
// - pwm: period match clears except in pulse code, duty sets duty
// - pwm raises both match flags, pulse code only the duty flag
// - pwm polarity and pin action select
// - invert bit inverts the output
// - zero period gives full-range period
// - pwm pin codes: off, on, wave, pulse
// - duty at or above period: always active
`timescale 1ns/10ps
module ptm_timer #(
   parameter bit WIDE_UNIT = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ptm_pkg::PTM_ADDR_W-1:0] paddr,
   input wire logic [ptm_pkg::PTM_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [ptm_pkg::PTM_DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic timer_out,
   output logic timer_out_oe,
   output logic match_a_flag,
   output logic match_p_flag
);
   import ptm_pkg::*;

   localparam logic [15:0] CNT_MASK = WIDE_UNIT ? PTM_MAX_WIDE : PTM_MAX_NARROW;

   // register state
   logic [7:0] ctrl_reg;
   logic [7:0] ctrl_next;
   logic [7:0] run_ctl_reg;
   logic [7:0] run_ctl_next;
   logic [15:0] duty_reg;
   logic [15:0] duty_next;
   logic [15:0] period_reg;
   logic [15:0] period_next;
   logic [1:0] flag_reg;
   logic [1:0] flag_next;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic slverr_reg;
   logic slverr_next;

   // timer state
   logic [15:0] cnt_reg;
   logic [15:0] cnt_next;
   logic [7:0] pre_reg;
   logic [7:0] pre_next;
   logic run_d_reg;
   logic run_d_next;
   logic pin_reg;
   logic pin_next;
   logic out_reg;
   logic out_next;
   logic oe_reg;
   logic oe_next;

   // decoded controls
   logic [1:0] mode;
   logic [1:0] io;
   logic oc;
   logic pol;
   logic cclr;
   logic run;
   logic [2:0] div_sel;
   logic [7:0] div_mask;
   logic run_rise;
   logic tick;
   logic [15:0] cnt_inc;
   logic hit_a;
   logic hit_p;
   logic pwm_mode;
   logic pulse_mode;
   logic cmp_like;
   logic a_clears;
   logic p_used;
   logic cnt_clear;
   logic set_a;
   logic set_p;
   logic pulse_end;
   logic pwm_wave;
   logic pwm_level;
   logic wr_en;
   logic rd_setup;
   logic [7:0] wbyte;

   assign mode = ctrl_reg[PTM_MODE_HI:PTM_MODE_LO];
   assign io = ctrl_reg[PTM_IO_HI:PTM_IO_LO];
   assign oc = ctrl_reg[PTM_OC_BIT];
   assign pol = ctrl_reg[PTM_POL_BIT];
   assign cclr = ctrl_reg[PTM_CCLR_BIT];
   assign run = run_ctl_reg[PTM_RUN_BIT];
   assign div_sel = run_ctl_reg[PTM_DIV_HI:PTM_DIV_LO];

   // bus handshake: zero wait states, read data latched in the setup cycle
   assign pready = psel & penable;
   assign wr_en = psel & penable & pwrite & pstrb[0];
   assign rd_setup = psel & ~penable;
   assign wbyte = pwdata[7:0];
   assign prdata = prdata_reg;
   assign pslverr = slverr_reg;
   assign match_a_flag = flag_reg[PTM_FLAG_A_BIT];
   assign match_p_flag = flag_reg[PTM_FLAG_P_BIT];
   assign timer_out = out_reg;
   assign timer_out_oe = oe_reg;

   // mode decode
   always_comb begin
      pwm_mode = (mode == PTM_MODE_PWM);
      pulse_mode = pwm_mode && (io == PTM_PWM_PULSE);
      cmp_like = (mode == PTM_MODE_CMP) || (mode == PTM_MODE_TMR);
      a_clears = cmp_like && cclr;
      p_used = !pulse_mode && !a_clears;
   end

   // prescaler and comparators
   always_comb begin
      run_rise = run && !run_d_reg;
      div_mask = (PTM_DIV_ONE << div_sel) - PTM_DIV_ONE;
      tick = run && !run_rise && ((pre_reg & div_mask) == div_mask);
      cnt_inc = (cnt_reg + 16'h0001) & CNT_MASK;
      hit_a = tick && (duty_reg != PTM_WORD_RST) && (cnt_inc == duty_reg);
      hit_p = tick && (period_reg != PTM_WORD_RST) && (cnt_inc == period_reg);
      cnt_clear = (a_clears && hit_a) || (p_used && hit_p);
      set_a = hit_a;
      set_p = p_used && hit_p;
      pulse_end = pulse_mode && hit_a;
   end

   // counter, prescaler and compare pin state
   always_comb begin
      cnt_next = cnt_reg;
      pre_next = pre_reg + 8'h01;
      run_d_next = run;
      pin_next = pin_reg;
      if (run_rise) begin
         cnt_next = PTM_WORD_RST;
         pre_next = PTM_BYTE_RST;
         pin_next = oc;
      end else if (tick) begin
         if (cnt_clear) begin
            cnt_next = PTM_WORD_RST;
         end else begin
            cnt_next = cnt_inc;
         end
         if ((mode == PTM_MODE_CMP) && hit_a) begin
            unique case (io)
               PTM_IO_NONE: pin_next = pin_reg;
               PTM_IO_LOW: pin_next = 1'b0;
               PTM_IO_HIGH: pin_next = 1'b1;
               PTM_IO_TOGGLE: pin_next = !pin_reg;
            endcase
         end
      end
   end

   // output waveform
   always_comb begin
      if ((period_reg != PTM_WORD_RST) && (duty_reg >= period_reg)) begin
         pwm_wave = 1'b1;
      end else begin
         pwm_wave = (cnt_reg < duty_reg);
      end
      unique case (io)
         PTM_PWM_INACT: pwm_level = !oc;
         PTM_PWM_ACT: pwm_level = oc;
         PTM_PWM_WAVE: pwm_level = pwm_wave ? oc : !oc;
         PTM_PWM_PULSE: pwm_level = run ? oc : !oc;
      endcase
      out_next = (pwm_mode ? pwm_level : pin_reg) ^ pol;
      oe_next = (mode == PTM_MODE_CMP) || pwm_mode;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= PTM_WORD_RST;
         pre_reg <= PTM_BYTE_RST;
         run_d_reg <= 1'b0;
         pin_reg <= 1'b0;
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         pre_reg <= pre_next;
         run_d_reg <= run_d_next;
         pin_reg <= pin_next;
         out_reg <= out_next;
         oe_reg <= oe_next;
      end
   end

   // register file
   always_comb begin
      ctrl_next = ctrl_reg;
      run_ctl_next = run_ctl_reg;
      duty_next = duty_reg;
      period_next = period_reg;
      prdata_next = prdata_reg;
      slverr_next = slverr_reg;
      flag_next = flag_reg;
      if (pulse_end) begin
         run_ctl_next[PTM_RUN_BIT] = 1'b0;
      end
      if (wr_en) begin
         unique case (paddr)
            PTM_OFS_CTRL: ctrl_next = wbyte;
            PTM_OFS_RUN: run_ctl_next = {4'h0, wbyte[PTM_DIV_HI:PTM_RUN_BIT]};
            PTM_OFS_DUTY_LO: duty_next[7:0] = wbyte;
            PTM_OFS_DUTY_HI: duty_next[15:8] = wbyte & CNT_MASK[15:8];
            PTM_OFS_PER_LO: period_next[7:0] = wbyte;
            PTM_OFS_PER_HI: period_next[15:8] = wbyte & CNT_MASK[15:8];
            PTM_OFS_FLAG: flag_next = flag_reg & ~wbyte[PTM_FLAG_P_BIT:PTM_FLAG_A_BIT];
            default: ;
         endcase
      end
      // hardware set wins over a same-cycle clear
      if (set_a) begin
         flag_next[PTM_FLAG_A_BIT] = 1'b1;
      end
      if (set_p) begin
         flag_next[PTM_FLAG_P_BIT] = 1'b1;
      end
      if (rd_setup) begin
         slverr_next = 1'b0;
         unique case (paddr)
            PTM_OFS_CTRL: prdata_next = {24'h00_0000, ctrl_reg};
            PTM_OFS_RUN: prdata_next = {24'h00_0000, run_ctl_reg};
            PTM_OFS_CNT_LO: prdata_next = {24'h00_0000, cnt_reg[7:0]};
            PTM_OFS_CNT_HI: prdata_next = {24'h00_0000, cnt_reg[15:8] & CNT_MASK[15:8]};
            PTM_OFS_DUTY_LO: prdata_next = {24'h00_0000, duty_reg[7:0]};
            PTM_OFS_DUTY_HI: prdata_next = {24'h00_0000, duty_reg[15:8]};
            PTM_OFS_PER_LO: prdata_next = {24'h00_0000, period_reg[7:0]};
            PTM_OFS_PER_HI: prdata_next = {24'h00_0000, period_reg[15:8]};
            PTM_OFS_FLAG: prdata_next = {30'h0000_0000, flag_reg};
            default: begin
               prdata_next = 32'h0000_0000;
               slverr_next = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= PTM_BYTE_RST;
         run_ctl_reg <= PTM_BYTE_RST;
         duty_reg <= PTM_WORD_RST;
         period_reg <= PTM_WORD_RST;
         flag_reg <= 2'h0;
         prdata_reg <= 32'h0000_0000;
         slverr_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         run_ctl_reg <= run_ctl_next;
         duty_reg <= duty_next;
         period_reg <= period_next;
         flag_reg <= flag_next;
         prdata_reg <= prdata_next;
         slverr_reg <= slverr_next;
      end
   end
endmodule : ptm_timer

// ### sim/ptm_timer_monitor.sv
/*
 ptm_timer_monitor: bus and flag checks on the timer ports.
 assumes: bound into ptm_timer, one clock, rst async active high.
*/
`timescale 1ns/10ps
module ptm_timer_monitor #(
   parameter bit WIDE_UNIT = 1'b1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ptm_pkg::PTM_ADDR_W-1:0] paddr,
   input wire logic [ptm_pkg::PTM_DATA_W-1:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [ptm_pkg::PTM_DATA_W-1:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic timer_out,
   input wire logic timer_out_oe,
   input wire logic match_a_flag,
   input wire logic match_p_flag
);
   import ptm_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence access_s;
      psel && penable;
   endsequence
   pready_follow_a: assert property (pready == (psel && penable)) else $error("pready wrong");
   upper_zero_a: assert property (prdata[31:8] == 24'h00_0000) else $error("prdata upper set");
   narrow_high_a: assert property (setup_s ##0 (!WIDE_UNIT && (paddr == PTM_OFS_CNT_HI ||
      paddr == PTM_OFS_DUTY_HI || paddr == PTM_OFS_PER_HI)) |=> prdata[7:2] == 6'h00) else $error("high bits set");
   unmapped_err_a: assert property (setup_s ##0 (paddr > PTM_OFS_FLAG) |=> pslverr) else $error("no pslverr");
   mapped_ok_a: assert property (setup_s ##0 (paddr <= PTM_OFS_FLAG) |=> !pslverr) else $error("bad pslverr");
   rdata_hold_a: assert property (access_s |=> $stable(prdata)) else $error("prdata moved");
   flag_a_sticky_a: assert property ($fell(match_a_flag) |-> $past(psel && penable && pwrite && pstrb[0] &&
      paddr == PTM_OFS_FLAG && pwdata[0])) else $error("a flag lost");
   flag_p_sticky_a: assert property ($fell(match_p_flag) |-> $past(psel && penable && pwrite && pstrb[0] &&
      paddr == PTM_OFS_FLAG && pwdata[1])) else $error("p flag lost");
endmodule : ptm_timer_monitor
bind ptm_timer ptm_timer_monitor #(.WIDE_UNIT(WIDE_UNIT)) u_mon (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .timer_out(timer_out), .timer_out_oe(timer_out_oe),
   .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// ### sim/tb_ptm_timer.sv
/*
 tb_ptm_timer: self-checking bench for a narrow timer unit.
 assumes: zero-wait apb slave, one tick per clock at prescale zero.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_ptm_timer;
   import ptm_pkg::*;
   logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready, pslverr, timer_out, timer_out_oe, match_a_flag, match_p_flag;
   logic [7:0] q[$];
   logic [7:0] e;
   int mismatches = 0, check_count = 0, cycles = 0, hi;
   int seed = 32'h7b1f;
   // io, initial level, invert, duty, period, high cycles in 2048, flags
   int pw[7][7] = '{'{2, 1, 0, 1, 4, 512, 3}, '{2, 1, 1, 1, 4, 1536, 3}, '{2, 0, 0, 1, 4, 1536, 3},
      '{2, 1, 0, 5, 4, 2048, 2}, '{0, 1, 0, 1, 4, 0, 3}, '{1, 1, 0, 1, 4, 2048, 3}, '{2, 1, 0, 512, 0, 1024, 1}};
   ptm_timer #(.WIDE_UNIT(1'b0)) u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_out(timer_out), .timer_out_oe(timer_out_oe), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
   initial forever #4 clk = ~clk;
   task automatic print_verdict();
      if (mismatches == 0 && check_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles > 30000) begin
         mismatches++;
         $display("ERROR %0t timeout", $time);
         print_verdict();
      end
   end
   // read results come off the queue in issue order
   always @(posedge clk) if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = q.pop_front();
      `CHK(prdata, {24'h00_0000, e})
      `CHK(pslverr, paddr > PTM_OFS_FLAG)
   end
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      pstrb <= {3'h0, w};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] x);
      q.push_back(x);
      apb(a, 1'b0, 8'h00);
   endtask : rd
   task automatic stop_flags(input logic [7:0] x);
      apb(PTM_OFS_RUN, 1'b1, 8'h00);
      `CHK({match_p_flag, match_a_flag}, x[1:0])
      rd(PTM_OFS_FLAG, x);
   endtask : stop_flags
   // stop, program, clear flags, start; returns one cycle after the run write
   task automatic cfg(input logic [7:0] c, input logic [15:0] du, input logic [15:0] pe);
      apb(PTM_OFS_RUN, 1'b1, 8'h00);
      apb(PTM_OFS_CTRL, 1'b1, c);
      apb(PTM_OFS_DUTY_LO, 1'b1, du[7:0]);
      apb(PTM_OFS_DUTY_HI, 1'b1, du[15:8]);
      apb(PTM_OFS_PER_LO, 1'b1, pe[7:0]);
      apb(PTM_OFS_PER_HI, 1'b1, pe[15:8]);
      apb(PTM_OFS_FLAG, 1'b1, 8'h03);
      apb(PTM_OFS_RUN, 1'b1, 8'h01);
   endtask : cfg
   initial begin
      logic [7:0] r, a8;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (int a = 0; a <= 36; a += 4) rd(8'(a), 8'h00);
      for (int i = 0; i < 4; i++) begin
         r = 8'($random(seed));
         a8 = PTM_OFS_DUTY_LO + 8'(4 * i);
         apb(a8, 1'b1, r);
         rd(a8, i[0] ? (r & 8'h03) : r);
      end
      apb(PTM_OFS_CNT_LO, 1'b1, 8'h55);
      rd(PTM_OFS_CNT_LO, 8'h00);
      for (int io = 0; io < 4; io++) begin
         cfg({PTM_MODE_CMP, 2'(io), ~io[1], 3'h0}, 16'h0003, 16'h0005);
         repeat (2) @(posedge clk);
         #1;
         `CHK(timer_out, ~io[1])
         `CHK(timer_out_oe, 1'b1)
         repeat (4) @(posedge clk);
         #1;
         `CHK(timer_out, io != 1)
      end
      stop_flags(8'h03);
      cfg({PTM_MODE_TMR, 6'h00}, 16'h0003, 16'h0005);
      repeat (2) @(posedge clk);
      #1;
      `CHK(timer_out_oe, 1'b0)
      repeat (20) @(posedge clk);
      stop_flags(8'h03);
      cfg({PTM_MODE_CMP, 5'h00, 1'b1}, 16'h0004, 16'h0002);
      repeat (30) @(posedge clk);
      stop_flags(8'h01);
      cfg({PTM_MODE_TMR, 6'h00}, 16'h0000, 16'h0000);
      repeat (1100) @(posedge clk);
      stop_flags(8'h00);
      for (int i = 0; i < 7; i++) begin
         cfg({PTM_MODE_PWM, 2'(pw[i][0]), 1'(pw[i][1]), 1'(pw[i][2]), 2'h0}, 16'(pw[i][3]), 16'(pw[i][4]));
         repeat (10) @(posedge clk);
         hi = 0;
         repeat (2048) begin
            @(negedge clk);
            hi += (timer_out === 1'b1);
         end
         `CHK(hi, pw[i][5])
         stop_flags(8'(pw[i][6]));
      end
      cfg({PTM_MODE_PWM, PTM_PWM_PULSE, 1'b1, 3'h0}, 16'h0007, 16'h0000);
      repeat (2) @(posedge clk);
      #1;
      `CHK(timer_out, 1'b1)
      repeat (20) @(posedge clk);
      #1;
      `CHK(timer_out, 1'b0)
      rd(PTM_OFS_RUN, 8'h00);
      rd(PTM_OFS_CNT_LO, 8'h07);
      rd(PTM_OFS_CNT_HI, 8'h00);
      print_verdict();
   end
endmodule : tb_ptm_timer
